//--- verilog/lcfg_regs.svh
// Register offsets, field positions, reset values and timing constants
// Summary of operation
// - Monitor field 00/10 normal; 01 receiver one watches channel two receive; 11 its transmit.
// - One global bit picks the line standard: 0 is E1, 1 is T1/J1; resets 0.
// - With broadcast set, a channel register write lands on both channels alike.
// - Global interrupt disable set suppresses all interrupts; it resets to one.
// - Interrupt pin style: x0 open-drain low, 01 push-pull low, 11 push-pull high.
// - Read-only indicator: bit n low means channel n+1 interrupted; bits 7-2 zero.
// - Transmit impedance 000/001/010/011 give 75/120/100/110 ohm; 1xx external.
// - Receive impedance uses the same codes; 1xx selects external resistors.
// - Attenuator placement 00/10 off, 01 transmit path, 11 receive path.
// - Attenuator depth 00 gives 128 bits, 01 gives 64, 1x gives 32.
// - Bandwidth bit 0 gives 6.8/5 Hz, 1 gives 0.9/1.25 Hz for E1/T1.
// - Software reset restores defaults and idles drivers but keeps the line standard.
`ifndef LCFG_REGS_SVH
`define LCFG_REGS_SVH

// Register offsets
`define LCFG_ADDR_SOFT_RESET 8'h01
`define LCFG_ADDR_IMP_CH1 8'h02
`define LCFG_ADDR_JA_CH1 8'h03
`define LCFG_ADDR_GLOBAL 8'h20
`define LCFG_ADDR_IRQ_CH 8'h21
`define LCFG_ADDR_IMP_CH2 8'h22
`define LCFG_ADDR_JA_CH2 8'h23

// Writable bit masks; reserved positions are cleared
`define LCFG_GLOBAL_WMASK 8'hDF
`define LCFG_IMP_WMASK 8'h3F
`define LCFG_JA_WMASK 8'h3F

// Reset values
`define LCFG_GLOBAL_RST 8'h04
`define LCFG_IMP_RST 8'h00
`define LCFG_JA_RST 8'h20

// Global register fields
`define LCFG_MON_HI 7
`define LCFG_MON_LO 6
`define LCFG_STD_BIT 4
`define LCFG_COPY_BIT 3
`define LCFG_GDIS_BIT 2
`define LCFG_PIN_HI 1
`define LCFG_PIN_LO 0

// Line impedance fields
`define LCFG_TTERM_HI 5
`define LCFG_TTERM_LO 3
`define LCFG_RTERM_HI 2
`define LCFG_RTERM_LO 0

// Jitter attenuator fields
`define LCFG_JLIM_BIT 5
`define LCFG_JPLC_HI 4
`define LCFG_JPLC_LO 3
`define LCFG_JDEP_HI 2
`define LCFG_JDEP_LO 1
`define LCFG_JBW_BIT 0

// Settling time after a line standard change
`define LCFG_SETTLE_NS 50000
`define LCFG_CLK_NS 4
`define LCFG_SETTLE_CYCLES ((`LCFG_SETTLE_NS + `LCFG_CLK_NS - 1) / `LCFG_CLK_NS)
`define LCFG_SETTLE_W 14

`endif

//--- verilog/lcfg_pkg.sv
// Types shared by the configuration register bank
package lcfg_pkg;

  typedef enum logic [1:0] {
    LCFG_TERM_75 = 2'b00,
    LCFG_TERM_120 = 2'b01,
    LCFG_TERM_100 = 2'b10,
    LCFG_TERM_110 = 2'b11
  } lcfg_term_t;

  typedef enum logic [1:0] {
    LCFG_JA_OFF = 2'b00,
    LCFG_JA_TX = 2'b01,
    LCFG_JA_RX = 2'b10
  } lcfg_ja_place_t;

  typedef enum logic [1:0] {
    LCFG_JA_128 = 2'b00,
    LCFG_JA_64 = 2'b01,
    LCFG_JA_32 = 2'b10
  } lcfg_ja_depth_t;

  typedef enum logic [1:0] {
    LCFG_BW_E1_6P8 = 2'b00,
    LCFG_BW_E1_0P9 = 2'b01,
    LCFG_BW_T1_5 = 2'b10,
    LCFG_BW_T1_1P25 = 2'b11
  } lcfg_ja_bw_t;

  typedef enum logic [1:0] {
    LCFG_MON_NORMAL = 2'b00,
    LCFG_MON_RX2 = 2'b01,
    LCFG_MON_TX2 = 2'b10
  } lcfg_mon_t;

  typedef enum logic [1:0] {
    LCFG_PIN_OD_LOW = 2'b00,
    LCFG_PIN_PP_LOW = 2'b01,
    LCFG_PIN_PP_HIGH = 2'b10
  } lcfg_pin_style_t;

  // Decoded per-channel line settings
  typedef struct packed {
    lcfg_term_t tx_term;
    logic tx_ext;
    lcfg_term_t rx_term;
    logic rx_ext;
    lcfg_ja_place_t ja_place;
    lcfg_ja_depth_t ja_depth;
    lcfg_ja_bw_t ja_bw;
    logic jitter_limit_mode;
  } lcfg_chan_cfg_t;

  // Host control port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lcfg_req_t;

endpackage

//--- verilog/lcfg_chan_decode.sv
// Decoder from one channel's raw register bytes to line settings
`include "lcfg_regs.svh"

module lcfg_chan_decode
  import lcfg_pkg::*;
(
  input wire logic [7:0] imp_i,
  input wire logic [7:0] ja_i,
  input wire logic t1_mode_i,
  output lcfg_chan_cfg_t cfg_o
);

  // Shared impedance code decode for both directions
  function automatic lcfg_term_t term_of(input logic [2:0] code);
    term_of = lcfg_term_t'(code[1:0]);
  endfunction

  wire logic [2:0] tx_code = imp_i[`LCFG_TTERM_HI:`LCFG_TTERM_LO];
  wire logic [2:0] rx_code = imp_i[`LCFG_RTERM_HI:`LCFG_RTERM_LO];
  wire logic [1:0] plc = ja_i[`LCFG_JPLC_HI:`LCFG_JPLC_LO];
  wire logic [1:0] dep = ja_i[`LCFG_JDEP_HI:`LCFG_JDEP_LO];
  wire logic bw = ja_i[`LCFG_JBW_BIT];

  // Termination: top code bit selects external resistors
  assign cfg_o.tx_term = term_of(tx_code);
  assign cfg_o.tx_ext = tx_code[2];
  assign cfg_o.rx_term = term_of(rx_code);
  assign cfg_o.rx_ext = rx_code[2];

  // Attenuator placement: low bit enables, high bit picks receive
  assign cfg_o.ja_place = !plc[0] ? LCFG_JA_OFF :
                          (plc[1] ? LCFG_JA_RX : LCFG_JA_TX);
  // Depth: any code with bit one set gives the shallowest buffer
  assign cfg_o.ja_depth = dep[1] ? LCFG_JA_32 :
                          (dep[0] ? LCFG_JA_64 : LCFG_JA_128);
  // Corner depends on both the bandwidth bit and the line standard
  assign cfg_o.ja_bw = lcfg_ja_bw_t'({t1_mode_i, bw});
  assign cfg_o.jitter_limit_mode = ja_i[`LCFG_JLIM_BIT];

endmodule

//--- verilog/lcfg_top.sv
// Global and per-channel line configuration register bank
`include "lcfg_regs.svh"

module lcfg_top
  import lcfg_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = `LCFG_SETTLE_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [1:0] chan_irq_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output lcfg_chan_cfg_t ch1_cfg_o,
  output lcfg_chan_cfg_t ch2_cfg_o,
  output lcfg_mon_t monitor_sel_o,
  output logic t1_mode_o,
  output logic line_settling_o,
  output logic soft_reset_o,
  output logic irq_pin_o,
  output logic irq_pin_oe_o
);

  // Host request bundle
  lcfg_req_t req;
  assign req.wr = wr_i;
  assign req.rd = rd_i;
  assign req.addr = addr_i;
  assign req.wdata = wdata_i;

  // Storage
  logic [7:0] global_q;
  logic [7:0] imp1_q;
  logic [7:0] ja1_q;
  logic [7:0] imp2_q;
  logic [7:0] ja2_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic soft_q;
  logic [`LCFG_SETTLE_W-1:0] settle_q;
  logic settle_busy_q;
  lcfg_chan_cfg_t ch1_q;
  lcfg_chan_cfg_t ch2_q;
  lcfg_mon_t mon_q;
  logic irq_pin_q;
  logic irq_oe_q;

  // Address decode
  wire logic hit_soft = req.addr == `LCFG_ADDR_SOFT_RESET;
  wire logic hit_glb = req.addr == `LCFG_ADDR_GLOBAL;
  wire logic hit_ich = req.addr == `LCFG_ADDR_IRQ_CH;
  wire logic hit_imp1 = req.addr == `LCFG_ADDR_IMP_CH1;
  wire logic hit_imp2 = req.addr == `LCFG_ADDR_IMP_CH2;
  wire logic hit_ja1 = req.addr == `LCFG_ADDR_JA_CH1;
  wire logic hit_ja2 = req.addr == `LCFG_ADDR_JA_CH2;

  // Global fields
  wire logic copy_on = global_q[`LCFG_COPY_BIT];
  wire logic gdis = global_q[`LCFG_GDIS_BIT];
  wire logic t1_mode = global_q[`LCFG_STD_BIT];
  wire logic [1:0] mon_code = global_q[`LCFG_MON_HI:`LCFG_MON_LO];
  wire logic [1:0] pin_code = global_q[`LCFG_PIN_HI:`LCFG_PIN_LO];

  // Write strobes; broadcast mirrors a channel write onto the other
  wire logic soft_wr = req.wr && hit_soft;
  wire logic glb_wr = req.wr && hit_glb;
  wire logic imp_any = hit_imp1 || hit_imp2;
  wire logic ja_any = hit_ja1 || hit_ja2;
  wire logic imp1_wr = req.wr && (hit_imp1 || (copy_on && imp_any));
  wire logic imp2_wr = req.wr && (hit_imp2 || (copy_on && imp_any));
  wire logic ja1_wr = req.wr && (hit_ja1 || (copy_on && ja_any));
  wire logic ja2_wr = req.wr && (hit_ja2 || (copy_on && ja_any));

  // Masked write data keeps reserved bits at zero
  wire logic [7:0] glb_wdata = req.wdata & `LCFG_GLOBAL_WMASK;
  wire logic [7:0] imp_wdata = req.wdata & `LCFG_IMP_WMASK;
  wire logic [7:0] ja_wdata = req.wdata & `LCFG_JA_WMASK;

  // Line standard change starts the settling window
  wire logic std_change = glb_wr &&
                          (glb_wdata[`LCFG_STD_BIT] != t1_mode);

  // Soft reset keeps the line standard bit, reloads the reset value into every other bit
  wire logic [7:0] glb_soft_val = (`LCFG_GLOBAL_RST &
                                   ~(8'h01 << `LCFG_STD_BIT)) |
                                  ({7'h00, t1_mode} << `LCFG_STD_BIT);

  // Interrupt gating and channel indication
  wire logic irq_active = (|chan_irq_i) && !gdis;
  wire logic [7:0] irq_ch_val = {6'h00, ~chan_irq_i};

  // Read multiplexer; unmapped and write-only offsets read zero
  wire logic [7:0] rd_mux = hit_glb ? global_q :
                            hit_ich ? irq_ch_val :
                            hit_imp1 ? imp1_q :
                            hit_imp2 ? imp2_q :
                            hit_ja1 ? ja1_q :
                            hit_ja2 ? ja2_q : 8'h00;

  // Decoded channel settings
  lcfg_chan_cfg_t ch1_d;
  lcfg_chan_cfg_t ch2_d;

  lcfg_chan_decode u_dec_ch1 (
    .imp_i(imp1_q),
    .ja_i(ja1_q),
    .t1_mode_i(t1_mode),
    .cfg_o(ch1_d)
  );

  lcfg_chan_decode u_dec_ch2 (
    .imp_i(imp2_q),
    .ja_i(ja2_q),
    .t1_mode_i(t1_mode),
    .cfg_o(ch2_d)
  );

  // Monitor routing: low bit enables, high bit picks transmit path
  wire lcfg_mon_t mon_d = !mon_code[0] ? LCFG_MON_NORMAL :
                          (mon_code[1] ? LCFG_MON_TX2 : LCFG_MON_RX2);

  // Pin style: low bit clear always means open drain
  wire lcfg_pin_style_t style = !pin_code[0] ? LCFG_PIN_OD_LOW :
                                (pin_code[1] ? LCFG_PIN_PP_HIGH :
                                 LCFG_PIN_PP_LOW);

  // Pin level and enable for each style
  logic irq_pin_d;
  logic irq_oe_d;
  always_comb begin
    irq_pin_d = 1'b0;
    irq_oe_d = 1'b0;
    unique case (style)
      LCFG_PIN_OD_LOW: begin
        irq_pin_d = 1'b0;
        irq_oe_d = irq_active;
      end
      LCFG_PIN_PP_LOW: begin
        irq_pin_d = !irq_active;
        irq_oe_d = 1'b1;
      end
      LCFG_PIN_PP_HIGH: begin
        irq_pin_d = irq_active;
        irq_oe_d = 1'b1;
      end
      default: begin
        irq_pin_d = 1'b0;
        irq_oe_d = 1'b0;
      end
    endcase
  end

  // Global configuration register
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      global_q <= `LCFG_GLOBAL_RST;
    end else if (soft_wr) begin
      global_q <= glb_soft_val;
    end else if (glb_wr) begin
      global_q <= glb_wdata;
    end
  end

  // Channel one registers; soft reset synchronously reloads the reset values
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      imp1_q <= `LCFG_IMP_RST;
      ja1_q <= `LCFG_JA_RST;
    end else if (soft_wr) begin
      imp1_q <= `LCFG_IMP_RST;
      ja1_q <= `LCFG_JA_RST;
    end else begin
      if (imp1_wr) imp1_q <= imp_wdata;
      if (ja1_wr) ja1_q <= ja_wdata;
    end
  end

  // Channel two registers; soft reset synchronously reloads the reset values
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      imp2_q <= `LCFG_IMP_RST;
      ja2_q <= `LCFG_JA_RST;
    end else if (soft_wr) begin
      imp2_q <= `LCFG_IMP_RST;
      ja2_q <= `LCFG_JA_RST;
    end else begin
      if (imp2_wr) imp2_q <= imp_wdata;
      if (ja2_wr) ja2_q <= ja_wdata;
    end
  end

  // Settling counter after a line standard change
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      settle_q <= '0;
      settle_busy_q <= 1'b0;
    end else if (std_change) begin
      settle_q <= `LCFG_SETTLE_W'(SETTLE_CYCLES - 1);
      settle_busy_q <= 1'b1;
    end else if (settle_q != '0) begin
      settle_q <= settle_q - 1'b1;
    end else begin
      settle_busy_q <= 1'b0;
    end
  end

  // Read data and soft reset pulse
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      soft_q <= 1'b0;
    end else begin
      rdata_q <= req.rd ? rd_mux : 8'h00;
      rvalid_q <= req.rd;
      soft_q <= soft_wr;
    end
  end

  // Registered decoded outputs
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ch1_q <= '0;
      ch2_q <= '0;
      mon_q <= LCFG_MON_NORMAL;
      irq_pin_q <= 1'b0;
      irq_oe_q <= 1'b0;
    end else begin
      ch1_q <= ch1_d;
      ch2_q <= ch2_d;
      mon_q <= mon_d;
      irq_pin_q <= irq_pin_d;
      irq_oe_q <= irq_oe_d;
    end
  end

  // Output connections
  assign rdata_o = rdata_q;
  assign rvalid_o = rvalid_q;
  assign ch1_cfg_o = ch1_q;
  assign ch2_cfg_o = ch2_q;
  assign monitor_sel_o = mon_q;
  assign t1_mode_o = global_q[`LCFG_STD_BIT];
  assign line_settling_o = settle_busy_q;
  assign soft_reset_o = soft_q;
  assign irq_pin_o = irq_pin_q;
  assign irq_pin_oe_o = irq_oe_q;

endmodule

//--- tb/lcfg_top_sva.sv
// Concurrent checks on the register bank ports
module lcfg_top_sva
  import lcfg_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] addr_i,
  input wire logic [1:0] chan_irq_i,
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  input wire lcfg_chan_cfg_t ch1_cfg_o,
  input wire logic t1_mode_o,
  input wire logic line_settling_o,
  input wire logic soft_reset_o,
  input wire logic irq_pin_o,
  input wire logic irq_pin_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic [15:0] run_q;
  logic [15:0] run_d;

  // Length of the current settling run
  assign run_d = line_settling_o ? run_q + 16'h0001 : 16'h0000;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) run_q <= 16'h0000;
    else run_q <= run_d;
  end

  sequence s_pulse;
    soft_reset_o ##1 !soft_reset_o;
  endsequence
  property p_rvalid;
    rd_i |=> rvalid_o;
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("no read valid");
  property p_rdata_idle;
    !rd_i |=> rdata_o == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("idle data");
  property p_irq_chan;
    rd_i && addr_i == 8'h21 |=> rdata_o == {6'h00, ~$past(chan_irq_i)};
  endproperty
  a_irq_chan: assert property (p_irq_chan) else $error("irq chan");
  property p_soft;
    wr_i && addr_i == 8'h01 |=> s_pulse and $stable(t1_mode_o);
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset");
  property p_settle_start;
    $changed(t1_mode_o) |-> line_settling_o;
  endproperty
  a_settle_start: assert property (p_settle_start) else $error("settle");
  property p_settle_len;
    $fell(line_settling_o) |-> run_q == SETTLE_CYCLES;
  endproperty
  a_settle_len: assert property (p_settle_len) else $error("settle len");
  property p_pin_od;
    !irq_pin_oe_o |-> !irq_pin_o;
  endproperty
  a_pin_od: assert property (p_pin_od) else $error("pin level");
  property p_bw;
    ##1 ch1_cfg_o.ja_bw[1] == $past(t1_mode_o);
  endproperty
  a_bw: assert property (p_bw) else $error("bandwidth std");
endmodule

bind lcfg_top lcfg_top_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) sva_u (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .wr_i(wr_i), .rd_i(rd_i),
  .addr_i(addr_i), .chan_irq_i(chan_irq_i), .rdata_o(rdata_o),
  .rvalid_o(rvalid_o), .ch1_cfg_o(ch1_cfg_o), .t1_mode_o(t1_mode_o),
  .line_settling_o(line_settling_o), .soft_reset_o(soft_reset_o),
  .irq_pin_o(irq_pin_o), .irq_pin_oe_o(irq_pin_oe_o));

//--- tb/lcfg_host.sv
// Host processor model on the register port
module lcfg_host #(
  parameter int unsigned SETTLE = 8
) (
  input wire logic core_clk_i,
  input wire logic [7:0] rdata_i,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'hA5;
    wdata_o = 8'h5A;
  end
  // Released bus lines show the inverse, never the last value
  task automatic idle();
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = ~addr_o;
    wdata_o = ~wdata_o;
  endtask
  // One write, then a spare cycle so decoded outputs have landed
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(negedge core_clk_i);
    idle();
    @(negedge core_clk_i);
  endtask
  // Read data is taken in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk_i);
    rd_o = 1'b1;
    addr_o = a;
    @(negedge core_clk_i);
    d = rdata_i;
    idle();
  endtask
  // Quiet time after a line standard change
  task automatic settle();
    repeat (SETTLE + 2) @(negedge core_clk_i);
  endtask
endmodule

//--- tb/lcfg_top_test.sv
// Self-checking bench for the configuration register bank
module lcfg_top_test
  import lcfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, wr, rd;
  logic [7:0] addr, wdata, rdata;
  logic [1:0] irq;
  lcfg_chan_cfg_t c1, c2;
  lcfg_mon_t mon;
  logic t1, settling, pin, oe;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;

  lcfg_top #(.SETTLE_CYCLES(8)) dut_u (.core_clk_i(clk), .rst_i(rst),
    .wr_i(wr), .rd_i(rd), .addr_i(addr), .wdata_i(wdata),
    .chan_irq_i(irq), .rdata_o(rdata), .rvalid_o(), .ch1_cfg_o(c1),
    .ch2_cfg_o(c2), .monitor_sel_o(mon), .t1_mode_o(t1),
    .line_settling_o(settling), .soft_reset_o(), .irq_pin_o(pin),
    .irq_pin_oe_o(oe));
  lcfg_host #(.SETTLE(8)) host_u (.core_clk_i(clk), .rdata_i(rdata),
    .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_u.rd_reg(a, d);
    chk($sformatf("reg %h", a), d, exp);
  endtask
  // Reset values, reserved and unmapped places
  task automatic t_reset();
    rchk(8'h20, 8'h04);
    rchk(8'h21, 8'h03);
    rchk(8'h02, 8'h00);
    rchk(8'h03, 8'h20);
    rchk(8'h40, 8'h00);
    chk("limit", c1.jitter_limit_mode, 8'h01);
    $display("t_reset done");
  endtask
  // Every impedance code, reserved bits set; E1 mode allows 1xx
  task automatic t_imp();
    logic [2:0] c;
    logic [7:0] d;
    chk("e1", t1, 8'h00);
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      d = {2'b11, c, ~c};
      host_u.wr_reg(8'h02, d);
      rchk(8'h02, d & 8'h3F);
      chk("tx", {c1.tx_ext, c1.tx_term}, c);
      chk("rx", {c1.rx_ext, c1.rx_term}, 3'(~c));
    end
    $display("t_imp done");
  endtask
  // Attenuator placement, depth and bandwidth on channel two
  task automatic t_ja();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      host_u.wr_reg(8'h23, {3'b000, c, c, c[0]});
      chk("place", c2.ja_place, c == 2'b01 ? LCFG_JA_TX :
          c == 2'b11 ? LCFG_JA_RX : LCFG_JA_OFF);
      chk("depth", c2.ja_depth, c[1] ? LCFG_JA_32 :
          c[0] ? LCFG_JA_64 : LCFG_JA_128);
      chk("bw", c2.ja_bw, {1'b0, c[0]});
    end
    $display("t_ja done");
  endtask
  // Monitor routing codes
  task automatic t_mon();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      host_u.wr_reg(8'h20, {c, 6'h04});
      chk("mon", mon, c == 2'b01 ? LCFG_MON_RX2 :
          c == 2'b11 ? LCFG_MON_TX2 : LCFG_MON_NORMAL);
    end
    host_u.wr_reg(8'h20, 8'h04);
    $display("t_mon done");
  endtask
  // Broadcast on, then off
  task automatic t_bcast();
    host_u.wr_reg(8'h20, 8'h0C);
    host_u.wr_reg(8'h02, 8'h09);
    rchk(8'h22, 8'h09);
    host_u.wr_reg(8'h20, 8'h04);
    host_u.wr_reg(8'h22, 8'h12);
    rchk(8'h02, 8'h09);
    rchk(8'h22, 8'h12);
    $display("t_bcast done");
  endtask
  // Global disable and pin styles: global byte, requests, pin, enable
  task automatic t_irq();
    logic [7:0] g [5] = '{8'h04, 8'h00, 8'h01, 8'h01, 8'h03};
    logic [1:0] q [5] = '{2'b01, 2'b01, 2'b01, 2'b00, 2'b10};
    logic [1:0] e [5] = '{2'b00, 2'b01, 2'b01, 2'b11, 2'b11};
    for (int i = 0; i < 5; i++) begin
      @(negedge clk);
      irq = q[i];
      host_u.wr_reg(8'h20, g[i]);
      chk("pin", {pin, oe}, e[i]);
      rchk(8'h21, {6'h00, ~q[i]});
    end
    irq = 2'b00;
    host_u.wr_reg(8'h20, 8'h04);
    $display("t_irq done");
  endtask
  // Line standard, settling and software reset
  task automatic t_std();
    host_u.wr_reg(8'h20, 8'h14);
    chk("t1", t1, 8'h01);
    chk("settling", settling, 8'h01);
    host_u.settle();
    chk("settle", settling, 8'h00);
    chk("bw t1", c1.ja_bw, 8'h02);
    host_u.wr_reg(8'h01, 8'h00);
    rchk(8'h20, 8'h14);
    rchk(8'h22, 8'h00);
    host_u.wr_reg(8'h20, 8'h04);
    host_u.settle();
    $display("t_std done");
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      stop_test();
    end
  end
  initial begin
    rst = 1'b1;
    irq = 2'b00;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_imp();
    t_ja();
    t_mon();
    t_bcast();
    t_irq();
    t_std();
    stop_test();
  end
endmodule
